// ---- bench/tb_timer_pwm_timebase.sv ----
// Self-checking testbench for the timer/PWM timebase
`timescale 1ns/100ps

module tb_timer_pwm_timebase;
    import tpwtb_pkg::*;

    localparam logic [2:0] A_SC = TPWTB_ADDR_STATUS_CONTROL;
    localparam logic [2:0] A_CH = TPWTB_ADDR_COUNTER_HIGH;
    localparam logic [2:0] A_CL = TPWTB_ADDR_COUNTER_LOW;
    localparam logic [2:0] A_MH = TPWTB_ADDR_MODULO_HIGH;
    localparam logic [2:0] A_ML = TPWTB_ADDR_MODULO_LOW;

    logic        sys_clk;
    logic        rst;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        fixed_system_clock;
    logic        external_timer_clock;
    logic        debug_active;
    logic [15:0] counter_value;
    logic        count_tick;
    logic        count_down;
    logic        center_align_mode;
    logic        overflow_irq;
    int          mismatches = 0;
    int          num_checks = 0;
    int          slow_div   = 0;
    logic [7:0]  rd_val;
    logic [15:0] snap;
    logic [15:0] held;

    tpwtb_timebase tpwtb_timebase_inst (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .fixed_system_clock   (fixed_system_clock),
        .external_timer_clock (external_timer_clock),
        .debug_active         (debug_active),
        .counter_value        (counter_value),
        .count_tick           (count_tick),
        .count_down           (count_down),
        .center_align_mode    (center_align_mode),
        .overflow_irq         (overflow_irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Slow sources: fixed at 1/8 and external at 1/12 of the bus rate
    always @(posedge sys_clk) begin
        slow_div             <= slow_div + 1;
        fixed_system_clock   <= (slow_div % 8) < 4;
        external_timer_clock <= (slow_div % 12) < 6;
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Snapshot holds the counter as it stands at the read edge
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        #1 snap = counter_value;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Always lets one edge pass first, so a stale value cannot match
    task automatic wait_count(input logic [15:0] v, input int limit);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > limit) begin
                mismatches++;
                $display("[ERR] counter wait expected %h seen %h", v, counter_value);
                tally_and_finish();
            end
        end while (counter_value !== v);
    endtask : wait_count

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    task automatic measure(input logic [7:0] sc, input int exp_cycles);
        int n;
        // Reset after the mode change so the old divider cannot run ahead
        reg_write(A_SC, sc);
        reg_write(A_CL, 8'h00);
        wait_count(16'h0002, 2000);
        n = 0;
        do begin
            step();
            n++;
        end while (counter_value === 16'h0002 && n < 2000);
        check("step interval", n[15:0], exp_cycles[15:0]);
        check("single step", counter_value, 16'h0003);
        check("tick pulse", count_tick, 1'b1);
    endtask : measure

    task automatic test_reset();
        for (int a = 0; a < 8; a++) begin
            reg_read(a[2:0], rd_val);
            check("reset read", rd_val, 8'h00);
        end
        check("reset counter", counter_value, TPWTB_COUNTER_RESET);
        check("reset center", center_align_mode, 1'b0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_prescale();
        for (int p = 0; p < 8; p++) begin
            measure(8'h08 | p[7:0], 1 << p);
        end
        measure(8'h10, 8);
        // No channel shares the external pin in this bench
        measure(8'h18, 12);
        reg_write(A_SC, 8'h00);
        step();
        held = counter_value;
        repeat (20) step();
        check("no clock hold", counter_value, held);
        check("no tick", count_tick, 1'b0);
        $display("test_prescale done");
    endtask : test_prescale

    task automatic test_latch();
        reg_write(A_CH, 8'hA5);
        #1 check("counter write", counter_value, 16'h0000);
        reg_write(A_SC, 8'h08);
        repeat (300) step();
        reg_read(A_CH, rd_val);
        held = snap;
        check("high byte", rd_val, held[15:8]);
        repeat (300) step();
        reg_read(A_CL, rd_val);
        check("latched low", rd_val, held[7:0]);
        reg_read(A_CL, rd_val);
        check("fresh low", rd_val, snap[7:0]);
        held = snap;
        repeat (300) step();
        reg_read(A_CH, rd_val);
        check("latched high", rd_val, held[15:8]);
        reg_read(A_CH, rd_val);
        reg_write(A_SC, 8'h08);
        repeat (300) step();
        reg_read(A_CL, rd_val);
        check("rearmed low", rd_val, snap[7:0]);
        reg_read(A_CH, rd_val);
        @(posedge sys_clk);
        debug_active <= 1'b1;
        step();
        step();
        held = counter_value;
        reg_read(A_CL, rd_val);
        repeat (20) step();
        check("debug freeze", counter_value, held);
        @(posedge sys_clk);
        debug_active <= 1'b0;
        repeat (300) step();
        reg_read(A_CH, rd_val);
        check("debug read no latch", rd_val, snap[15:8]);
        held = snap;
        reg_read(A_CL, rd_val);
        check("debug pair low", rd_val, held[7:0]);
        $display("test_latch done");
    endtask : test_latch

    task automatic test_flag();
        reg_write(A_SC, 8'h00);
        reg_write(A_MH, 8'h00);
        reg_write(A_ML, 8'h05);
        reg_write(A_CL, 8'h00);
        reg_write(A_SC, 8'h48);
        wait_count(16'h0005, 50);
        step();
        check("wrap to zero", counter_value, 16'h0000);
        step();
        check("irq raised", overflow_irq, 1'b1);
        reg_read(A_SC, rd_val);
        check("flag on wrap", rd_val, 8'hC8);
        wait_count(16'h0005, 50);
        step();
        reg_write(A_SC, 8'h40);
        reg_read(A_SC, rd_val);
        check("restarted clear", rd_val, 8'hC0);
        reg_write(A_SC, 8'hC0);
        reg_read(A_SC, rd_val);
        check("write one", rd_val, 8'hC0);
        reg_write(A_SC, 8'hC0);
        reg_write(A_SC, 8'h40);
        reg_read(A_SC, rd_val);
        check("no read no clear", rd_val, 8'hC0);
        reg_write(A_SC, 8'h00);
        reg_read(A_SC, rd_val);
        check("flag cleared", rd_val, 8'h00);
        check("irq dropped", overflow_irq, 1'b0);
        $display("test_flag done");
    endtask : test_flag

    task automatic test_mod_pair();
        reg_write(A_CL, 8'h00);
        reg_write(A_SC, 8'h08);
        reg_write(A_MH, 8'h00);
        wait_count(16'h0005, 50);
        wait_count(16'h0000, 50);
        reg_read(A_SC, rd_val);
        check("flag inhibited", rd_val, 8'h08);
        reg_write(A_ML, 8'h05);
        wait_count(16'h0005, 50);
        wait_count(16'h0000, 50);
        reg_read(A_SC, rd_val);
        check("flag after pair", rd_val, 8'h88);
        reg_write(A_SC, 8'h00);
        $display("test_mod_pair done");
    endtask : test_mod_pair

    task automatic test_center();
        reg_write(A_ML, 8'h04);
        reg_write(A_MH, 8'h00);
        reg_write(A_CL, 8'h00);
        reg_write(A_SC, 8'h28);
        #1 check("center select", center_align_mode, 1'b1);
        reg_read(A_SC, rd_val);
        check("no early flag", rd_val, 8'h28);
        wait_count(16'h0004, 50);
        step();
        check("turn down", counter_value, 16'h0003);
        check("count down", count_down, 1'b1);
        reg_read(A_SC, rd_val);
        check("center flag", rd_val, 8'hA8);
        reg_write(A_SC, 8'h00);
        $display("test_center done");
    endtask : test_center

    task automatic test_full_range();
        reg_write(A_MH, 8'hFF);
        reg_write(A_ML, 8'hFF);
        reg_write(A_CL, 8'h00);
        reg_write(A_SC, 8'h08);
        wait_count(TPWTB_MODULO_ALL1, 70000);
        step();
        check("full wrap", counter_value, 16'h0000);
        reg_read(A_SC, rd_val);
        check("full flag", rd_val, 8'h88);
        $display("test_full_range done");
    endtask : test_full_range

    initial begin
        rst          = 1'b1;
        reg_addr     = 3'h0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        debug_active = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_prescale();
        test_latch();
        test_flag();
        test_mod_pair();
        test_center();
        test_full_range();
        tally_and_finish();
    end

endmodule : tb_timer_pwm_timebase

// ---- verilog/tpwtb_pkg.sv ----
// Constants and types shared by the timer/PWM timebase
package tpwtb_pkg;

    // Register addresses on the 3-bit register port
    localparam logic [2:0] TPWTB_ADDR_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] TPWTB_ADDR_COUNTER_HIGH   = 3'h1;
    localparam logic [2:0] TPWTB_ADDR_COUNTER_LOW    = 3'h2;
    localparam logic [2:0] TPWTB_ADDR_MODULO_HIGH    = 3'h3;
    localparam logic [2:0] TPWTB_ADDR_MODULO_LOW     = 3'h4;

    // Field positions in timer_status_control
    localparam int TPWTB_BIT_OVERFLOW_FLAG  = 7;
    localparam int TPWTB_BIT_OVERFLOW_IE    = 6;
    localparam int TPWTB_BIT_CENTER_ALIGN   = 5;
    localparam int TPWTB_CLKS_MSB           = 4;
    localparam int TPWTB_CLKS_LSB           = 3;
    localparam int TPWTB_PS_MSB             = 2;
    localparam int TPWTB_PS_LSB             = 0;

    // Reset and limit values
    localparam logic [15:0] TPWTB_COUNTER_RESET = 16'h0000;
    localparam logic [15:0] TPWTB_MODULO_RESET  = 16'h0000;
    localparam logic [15:0] TPWTB_MODULO_ALL1   = 16'hFFFF;
    localparam logic [2:0]  TPWTB_PS_RESET      = 3'h0;
    localparam logic [7:0]  TPWTB_RDATA_UNMAPPED = 8'h00;
    localparam logic [6:0]  TPWTB_PRESCALE_RESET = 7'h00;

    // Clock source selection codes
    typedef enum logic [1:0] {
        TPWTB_SRC_NONE  = 2'h0,
        TPWTB_SRC_BUS   = 2'h1,
        TPWTB_SRC_FIXED = 2'h2,
        TPWTB_SRC_EXT   = 2'h3
    } tpwtb_src_t;

    // Count direction, one-hot
    typedef enum logic [1:0] {
        TPWTB_DIR_UP   = 2'b01,
        TPWTB_DIR_DOWN = 2'b10
    } tpwtb_dir_t;

endpackage : tpwtb_pkg

// ---- verilog/tpwtb_timebase.sv ----
// Timer/PWM timebase: clock select, prescaler, 16-bit counter, modulo and overflow
//
// Function
// - Up mode: flag set on wrap to zero
// - Center mode: flag set stepping down from modulo
// - Flag cleared by read-then-write-zero sequence
// - New overflow restarts clear sequence
// - Writing one ignored; reset clears flag
// - Interrupt when flag and enable; reset clears
// - Center select: up/down counting, reset clears
// - Clock source field selects prescaler input
// - Fixed and external clocks synchronized first
// - Prescaler divides by two to field power
// - Counter byte read latches both bytes
// - Latch rearmed by reset or counter or status/control writes
// - Reset clears counter
// - Debug mode freezes counter and latch
// - At modulo: restart zero or count down
// - Modulo byte write inhibits flag until pair
// - Reset loads modulo with zero
// - Any counter byte write resets counter
// - Modulo zero or all ones: free-running
`timescale 1ns/100ps

module tpwtb_timebase
    import tpwtb_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Clock pins and debug state
    input  wire logic        fixed_system_clock,
    input  wire logic        external_timer_clock,
    input  wire logic        debug_active,
    // To channel logic and interrupt controller
    output logic      [15:0] counter_value,
    output logic             count_tick,
    output logic             count_down,
    output logic             center_align_mode,
    output logic             overflow_irq
);

    logic        overflow_flag_reg;
    logic        overflow_irq_enable_reg;
    logic        center_align_select_reg;
    tpwtb_src_t  clock_source_select_reg;
    logic [2:0]  prescale_select_reg;
    logic        clear_armed_reg;

    logic [15:0] counter_reg;
    logic [15:0] counter_next;
    tpwtb_dir_t  dir_reg;
    tpwtb_dir_t  dir_next;
    logic [15:0] modulo_reg;
    logic        mod_high_seen_reg;
    logic        mod_low_seen_reg;

    logic [15:0] latch_reg;
    logic        latched_reg;
    logic        latch_first_high_reg;

    logic        fixed_meta_reg;
    logic        fixed_sync_reg;
    logic        fixed_prev_reg;
    logic        ext_meta_reg;
    logic        ext_sync_reg;
    logic        ext_prev_reg;
    logic [6:0]  prescale_reg;
    logic [6:0]  prescale_mask;

    logic [7:0]  rdata_reg;
    logic        irq_reg;
    logic        tick_reg;

    logic        wr_sc;
    logic        rd_sc;
    logic        wr_cnt;
    logic        rd_cnt;
    logic        wr_mod_high;
    logic        wr_mod_low;
    logic        src_tick;
    logic        pre_tick;
    logic        step;
    logic [15:0] limit;
    logic        overflow_event;
    logic        mod_inhibit;
    logic [15:0] counter_view;

    // Bus decode
    assign wr_sc       = reg_wr && (reg_addr == TPWTB_ADDR_STATUS_CONTROL);
    assign rd_sc       = reg_rd && (reg_addr == TPWTB_ADDR_STATUS_CONTROL);
    assign wr_cnt      = reg_wr && ((reg_addr == TPWTB_ADDR_COUNTER_HIGH)
                                 || (reg_addr == TPWTB_ADDR_COUNTER_LOW));
    assign rd_cnt      = reg_rd && ((reg_addr == TPWTB_ADDR_COUNTER_HIGH)
                                 || (reg_addr == TPWTB_ADDR_COUNTER_LOW));
    assign wr_mod_high = reg_wr && (reg_addr == TPWTB_ADDR_MODULO_HIGH);
    assign wr_mod_low  = reg_wr && (reg_addr == TPWTB_ADDR_MODULO_LOW);

    // Two-stage synchronizers; the edge detector reads only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fixed_meta_reg <= 1'b0;
            fixed_sync_reg <= 1'b0;
            fixed_prev_reg <= 1'b0;
            ext_meta_reg   <= 1'b0;
            ext_sync_reg   <= 1'b0;
            ext_prev_reg   <= 1'b0;
        end else begin
            fixed_meta_reg <= fixed_system_clock;
            fixed_sync_reg <= fixed_meta_reg;
            fixed_prev_reg <= fixed_sync_reg;
            ext_meta_reg   <= external_timer_clock;
            ext_sync_reg   <= ext_meta_reg;
            ext_prev_reg   <= ext_sync_reg;
        end
    end

    // Rising edges only count; a pin faster than half of sys_clk aliases
    always_comb begin
        unique case (clock_source_select_reg)
            TPWTB_SRC_NONE:  src_tick = 1'b0;
            TPWTB_SRC_BUS:   src_tick = 1'b1;
            TPWTB_SRC_FIXED: src_tick = fixed_sync_reg && !fixed_prev_reg;
            TPWTB_SRC_EXT:   src_tick = ext_sync_reg && !ext_prev_reg;
        endcase
    end

    // Prescaler after source selection
    assign prescale_mask = 7'((8'h01 << prescale_select_reg) - 8'h01);
    assign pre_tick      = src_tick && ((prescale_reg & prescale_mask) == prescale_mask);
    assign step          = pre_tick && !debug_active;

    always_ff @(posedge sys_clk) begin
        if (rst || wr_cnt) begin
            prescale_reg <= TPWTB_PRESCALE_RESET;
        end else if (src_tick && !debug_active) begin
            prescale_reg <= prescale_reg + 7'h01;
        end
    end

    // Counter range and direction
    assign limit = ((modulo_reg == TPWTB_MODULO_RESET) || (modulo_reg == TPWTB_MODULO_ALL1))
                 ? TPWTB_MODULO_ALL1 : modulo_reg;

    always_comb begin
        counter_next   = counter_reg;
        dir_next       = dir_reg;
        overflow_event = 1'b0;
        if (!center_align_select_reg) begin
            dir_next = TPWTB_DIR_UP;
            if (counter_reg == limit) begin
                counter_next   = TPWTB_COUNTER_RESET;
                overflow_event = 1'b1;
            end else begin
                counter_next = counter_reg + 16'h0001;
            end
        end else begin
            unique case (dir_reg)
                TPWTB_DIR_UP: begin
                    if (counter_reg == limit) begin
                        counter_next   = counter_reg - 16'h0001;
                        dir_next       = TPWTB_DIR_DOWN;
                        overflow_event = 1'b1;
                    end else begin
                        counter_next = counter_reg + 16'h0001;
                    end
                end
                TPWTB_DIR_DOWN: begin
                    if (counter_reg == TPWTB_COUNTER_RESET) begin
                        counter_next = counter_reg + 16'h0001;
                        dir_next     = TPWTB_DIR_UP;
                    end else begin
                        counter_next = counter_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || wr_cnt) begin
            counter_reg <= TPWTB_COUNTER_RESET;
            dir_reg     <= TPWTB_DIR_UP;
        end else if (step) begin
            counter_reg <= counter_next;
            dir_reg     <= dir_next;
        end
    end

    // Modulo bytes go live at once; only the flag waits for the pair
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modulo_reg <= TPWTB_MODULO_RESET;
        end else if (wr_mod_high) begin
            modulo_reg[15:8] <= reg_wdata;
        end else if (wr_mod_low) begin
            modulo_reg[7:0] <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mod_high_seen_reg <= 1'b0;
            mod_low_seen_reg  <= 1'b0;
        end else if ((wr_mod_high && mod_low_seen_reg) || (wr_mod_low && mod_high_seen_reg)) begin
            mod_high_seen_reg <= 1'b0;
            mod_low_seen_reg  <= 1'b0;
        end else begin
            mod_high_seen_reg <= mod_high_seen_reg || wr_mod_high;
            mod_low_seen_reg  <= mod_low_seen_reg || wr_mod_low;
        end
    end

    assign mod_inhibit = mod_high_seen_reg || mod_low_seen_reg;

    // Overflow flag; a new overflow wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_flag_reg <= 1'b0;
        end else if (step && overflow_event && !mod_inhibit) begin
            overflow_flag_reg <= 1'b1;
        end else if (wr_sc && clear_armed_reg && !reg_wdata[TPWTB_BIT_OVERFLOW_FLAG]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_armed_reg <= 1'b0;
        end else if (step && overflow_event && !mod_inhibit) begin
            clear_armed_reg <= 1'b0;
        end else if (wr_sc) begin
            clear_armed_reg <= 1'b0;
        end else if (rd_sc && overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;
        end
    end

    // Control fields
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_irq_enable_reg <= 1'b0;
            center_align_select_reg <= 1'b0;
            clock_source_select_reg <= TPWTB_SRC_NONE;
            prescale_select_reg     <= TPWTB_PS_RESET;
        end else if (wr_sc) begin
            overflow_irq_enable_reg <= reg_wdata[TPWTB_BIT_OVERFLOW_IE];
            center_align_select_reg <= reg_wdata[TPWTB_BIT_CENTER_ALIGN];
            clock_source_select_reg <= tpwtb_src_t'(reg_wdata[TPWTB_CLKS_MSB:TPWTB_CLKS_LSB]);
            prescale_select_reg     <= reg_wdata[TPWTB_PS_MSB:TPWTB_PS_LSB];
        end
    end

    // Coherent counter read latch
    always_ff @(posedge sys_clk) begin
        if (rst || wr_cnt || wr_sc) begin
            latched_reg          <= 1'b0;
            latch_first_high_reg <= 1'b0;
            latch_reg            <= TPWTB_COUNTER_RESET;
        end else if (rd_cnt && !debug_active) begin
            if (!latched_reg) begin
                latched_reg          <= 1'b1;
                latch_reg            <= counter_reg;
                latch_first_high_reg <= (reg_addr == TPWTB_ADDR_COUNTER_HIGH);
            end else if ((reg_addr == TPWTB_ADDR_COUNTER_HIGH) != latch_first_high_reg) begin
                latched_reg <= 1'b0;
            end
        end
    end

    assign counter_view = latched_reg ? latch_reg : counter_reg;

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (rst || !reg_rd) begin
            rdata_reg <= TPWTB_RDATA_UNMAPPED;
        end else begin
            unique case (reg_addr)
                TPWTB_ADDR_STATUS_CONTROL: rdata_reg <= {overflow_flag_reg,
                    overflow_irq_enable_reg, center_align_select_reg,
                    clock_source_select_reg, prescale_select_reg};
                TPWTB_ADDR_COUNTER_HIGH: rdata_reg <= counter_view[15:8];
                TPWTB_ADDR_COUNTER_LOW:  rdata_reg <= counter_view[7:0];
                TPWTB_ADDR_MODULO_HIGH:  rdata_reg <= modulo_reg[15:8];
                TPWTB_ADDR_MODULO_LOW:   rdata_reg <= modulo_reg[7:0];
                default:                 rdata_reg <= TPWTB_RDATA_UNMAPPED;
            endcase
        end
    end

    // Registered outputs; irq lags the flag by one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_reg  <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            irq_reg  <= overflow_flag_reg && overflow_irq_enable_reg;
            tick_reg <= step;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign counter_value     = counter_reg;
    assign count_tick        = tick_reg;
    assign count_down        = (dir_reg == TPWTB_DIR_DOWN);
    assign center_align_mode = center_align_select_reg;
    assign overflow_irq      = irq_reg;

    up_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
        step && !center_align_select_reg && counter_reg == limit && !wr_cnt
        |=> counter_reg == 16'h0000)
        else $error("counter did not wrap to zero at limit");

    center_turn_a: assert property (@(posedge sys_clk) disable iff (rst)
        step && center_align_select_reg && dir_reg == TPWTB_DIR_UP
        && counter_reg == limit && !mod_inhibit && !wr_cnt
        |=> count_down && overflow_flag_reg)
        else $error("center mode did not turn down with flag");

    flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(overflow_flag_reg) |-> $past(wr_sc && clear_armed_reg))
        else $error("flag cleared without read-write sequence");

    restart_a: assert property (@(posedge sys_clk) disable iff (rst)
        step && overflow_event && !mod_inhibit |=> overflow_flag_reg && !clear_armed_reg)
        else $error("overflow did not restart clear sequence");

    irq_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 overflow_irq == $past(overflow_flag_reg && overflow_irq_enable_reg))
        else $error("irq does not follow flag and enable");

    cnt_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_cnt |=> counter_value == 16'h0000 && !latched_reg)
        else $error("counter write did not reset counter");

    freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
        debug_active && !wr_cnt && !wr_sc |=> $stable(counter_reg) && $stable(latched_reg))
        else $error("debug mode did not freeze counter");

    latch_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(latched_reg) |-> latch_reg == $past(counter_reg))
        else $error("latch did not capture counter");

    inhibit_a: assert property (@(posedge sys_clk) disable iff (rst)
        mod_inhibit && !overflow_flag_reg |=> !overflow_flag_reg)
        else $error("flag set while modulo pair incomplete");

    no_clock_a: assert property (@(posedge sys_clk) disable iff (rst)
        clock_source_select_reg == TPWTB_SRC_NONE && !wr_cnt |=> $stable(counter_reg))
        else $error("counter moved with no clock selected");

    flag_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_sc && reg_wdata[TPWTB_BIT_OVERFLOW_FLAG] && overflow_flag_reg
        |=> overflow_flag_reg)
        else $error("writing one changed the flag");

    latch_rearm_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_sc || wr_cnt |=> !latched_reg)
        else $error("latch not released by write");

    free_run_a: assert property (@(posedge sys_clk) disable iff (rst)
        step && !center_align_select_reg && modulo_reg == TPWTB_MODULO_RESET
        && counter_reg != TPWTB_MODULO_ALL1 && !wr_cnt
        |=> counter_reg == $past(counter_reg) + 16'h0001)
        else $error("zero modulo did not free-run");

endmodule : tpwtb_timebase
